// [design/hpp_pkg.sv]
// Package for the host processor port: address map, timing and carriers
package hpp_pkg;

  // Clock and timing
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          WAIT_TIME_PS   = 20000;
  localparam int          WAIT_CYCLES    = (WAIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          TICK_TIME_PS   = 1000000;
  localparam int          TICK_CYCLES    = TICK_TIME_PS / CLK_PERIOD_PS;

  // Sizes
  localparam int          NUM_TIMERS     = 8;
  localparam int          NUM_METERS     = 10;
  localparam int          TIMER_W        = 16;
  localparam int          IND_DEPTH      = 16;
  localparam int          IND_AW         = 4;

  // Direct address map (byte addresses in the 256-byte space)
  localparam logic [7:0]  ADDR_TIMER_BASE = 8'h00;
  localparam logic [7:0]  ADDR_METER_BASE = 8'h10;
  localparam logic [7:0]  ADDR_TIMER_EN   = 8'h24;
  localparam logic [7:0]  ADDR_EVT_STAT   = 8'h25;
  localparam logic [7:0]  ADDR_EVT_MASK   = 8'h26;
  localparam logic [7:0]  ADDR_IND_SEL    = 8'h28;
  localparam logic [7:0]  ADDR_IND_DATA   = 8'h2C;
  localparam logic [1:0]  IND_LAST_BYTE   = 2'h3;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

  // Reset values
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_WORD        = 16'h0000;

  // Strap encodings
  localparam logic        STYLE_FIRST     = 1'b0;
  localparam logic        STYLE_SECOND    = 1'b1;
  localparam logic        RW_READ         = 1'b1;

  // One taken bus access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       write;
  } hpp_access_t;

  typedef enum logic [1:0] {
    HPP_IDLE,
    HPP_WAIT,
    HPP_HOLD
  } hpp_state_t;

endpackage

// [design/hpp_host_processor_port.sv]
// Host processor port: strobe decode, wait states, timers, meters, indirect space
`timescale 1ns/100ps

// Function
// - Decode one 256-byte direct address space
// - Select plus data registers reach indirect memory
// - Strap picks one of two strobe conventions
// - Strap picks multiplexed or split address/data
// - Multibyte values little-endian, lowest byte first
// - Ready output stretches access with waits
// - Interrupt request on time-critical events
// - Eight 16-bit timers, ten meters reachable
// - Style strap low first, high second convention
module hpp_host_processor_port #(
  parameter int WAIT_CYC = hpp_pkg::WAIT_CYCLES,
  parameter int TICK_CYC = hpp_pkg::TICK_CYCLES
) (
  input  wire logic                    mclk_i,                // 200 MHz clock
  input  wire logic                    rstn_i,                // Async reset, active low
  input  wire logic                    bus_style_select_i,    // Strobe convention strap
  input  wire logic                    addr_data_mux_select_i,// 1: shared address/data
  input  wire logic                    cs_n_i,                // Chip select, active low
  input  wire logic                    rd_ds_n_i,             // Read or data strobe, low
  input  wire logic                    wr_rw_i,               // Write low, or read/write
  input  wire logic                    ale_i,                 // Address latch, high
  input  wire logic [7:0]              addr_i,                // Split address lines
  input  wire logic [7:0]              ad_i,                  // Data/address lines in
  output logic      [7:0]              ad_o,                  // Data lines out
  output logic                         ad_oe_o,               // Data lines drive enable
  output logic                         ready_oe_o,            // Pulls ready low (waiting)
  output logic                         irq_oe_o,              // Pulls interrupt low
  input  wire logic [9:0][15:0]        meter_i,               // Meter readings
  output logic [7:0]                   timer_expired_o        // Timer wrap pulses
);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode
  logic                 strobe_act;
  logic                 is_read;
  logic [7:0]           cur_addr;
  logic [7:0]           mux_addr_r;
  hpp_pkg::hpp_state_t  state_r;
  logic [7:0]           wait_cnt_r;
  hpp_pkg::hpp_access_t acc_r;
  logic                 wr_pulse_r;

  always_comb begin
    if (bus_style_select_i == hpp_pkg::STYLE_FIRST) begin
      strobe_act = !cs_n_i && (!rd_ds_n_i || !wr_rw_i);
      is_read    = !rd_ds_n_i;
    end else begin
      strobe_act = !cs_n_i && !rd_ds_n_i;
      is_read    = (wr_rw_i == hpp_pkg::RW_READ);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mux_addr_r <= hpp_pkg::RST_BYTE;
    end else if (ale_i) begin
      mux_addr_r <= ad_i;
    end
  end

  assign cur_addr = addr_data_mux_select_i ? mux_addr_r : addr_i;

  ////////////////////////////////////////////////////////////////////////////
  // Internal state
  logic [7:0][15:0]                 timer_reload_r;
  logic [7:0][15:0]                 timer_cnt_r;
  logic [7:0]                       timer_en_r;
  logic [7:0]                       evt_stat_r;
  logic [7:0]                       evt_mask_r;
  logic [hpp_pkg::IND_AW-1:0]       ind_sel_r;
  logic [3:0][7:0]                  ind_data_r;
  logic [31:0]                      ind_mem [hpp_pkg::IND_DEPTH];
  logic [31:0]                      tick_cnt_r;
  logic                             tick_r;
  logic [7:0]                       expire;

  // Range test used by both read and write decode
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
                                    input int nbytes);
    in_range = (a >= base) && ({24'h000000, a} < ({24'h000000, base} + 32'(nbytes)));
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] off;
    off     = 8'h00;
    rd_byte = hpp_pkg::UNMAPPED_DATA;
    if (in_range(a, hpp_pkg::ADDR_TIMER_BASE, 2 * hpp_pkg::NUM_TIMERS)) begin
      off     = a - hpp_pkg::ADDR_TIMER_BASE;
      rd_byte = off[0] ? timer_cnt_r[off[3:1]][15:8] : timer_cnt_r[off[3:1]][7:0];
    end else if (in_range(a, hpp_pkg::ADDR_METER_BASE, 2 * hpp_pkg::NUM_METERS)) begin
      off     = a - hpp_pkg::ADDR_METER_BASE;
      rd_byte = off[0] ? meter_i[off[4:1]][15:8] : meter_i[off[4:1]][7:0];
    end else if (a == hpp_pkg::ADDR_TIMER_EN) begin
      rd_byte = timer_en_r;
    end else if (a == hpp_pkg::ADDR_EVT_STAT) begin
      rd_byte = evt_stat_r;
    end else if (a == hpp_pkg::ADDR_EVT_MASK) begin
      rd_byte = evt_mask_r;
    end else if (a == hpp_pkg::ADDR_IND_SEL) begin
      rd_byte = 8'(ind_sel_r);
    end else if (in_range(a, hpp_pkg::ADDR_IND_DATA, 4)) begin
      off     = a - hpp_pkg::ADDR_IND_DATA;
      rd_byte = ind_data_r[off[1:0]];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r    <= hpp_pkg::HPP_IDLE;
      wait_cnt_r <= hpp_pkg::RST_BYTE;
      acc_r      <= '0;
      wr_pulse_r <= 1'b0;
      ad_o       <= hpp_pkg::RST_BYTE;
      ad_oe_o    <= 1'b0;
      ready_oe_o <= 1'b0;
    end else begin
      wr_pulse_r <= 1'b0;
      unique case (state_r)
        hpp_pkg::HPP_IDLE: begin
          if (strobe_act) begin
            acc_r.addr <= cur_addr;
            acc_r.write <= !is_read;
            wait_cnt_r <= 8'(WAIT_CYC - 1);
            ready_oe_o <= 1'b1;
            state_r    <= hpp_pkg::HPP_WAIT;
          end
        end
        hpp_pkg::HPP_WAIT: begin
          if (wait_cnt_r == hpp_pkg::RST_BYTE) begin
            ready_oe_o <= 1'b0;
            state_r    <= hpp_pkg::HPP_HOLD;
            if (acc_r.write) begin
              acc_r.data <= ad_i;
              wr_pulse_r <= 1'b1;
            end else begin
              ad_o    <= rd_byte(acc_r.addr);
              ad_oe_o <= 1'b1;
            end
          end else begin
            wait_cnt_r <= wait_cnt_r - 8'h01;
          end
        end
        hpp_pkg::HPP_HOLD: begin
          if (!strobe_act) begin
            ad_oe_o <= 1'b0;
            state_r <= hpp_pkg::HPP_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  logic [7:0] woff;
  assign woff = acc_r.addr - hpp_pkg::ADDR_TIMER_BASE;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_reload_r <= '0;
      timer_en_r     <= hpp_pkg::RST_BYTE;
      evt_mask_r     <= hpp_pkg::RST_BYTE;
    end else if (wr_pulse_r) begin
      if (in_range(acc_r.addr, hpp_pkg::ADDR_TIMER_BASE, 2 * hpp_pkg::NUM_TIMERS)) begin
        if (woff[0]) begin
          timer_reload_r[woff[3:1]][15:8] <= acc_r.data;
        end else begin
          timer_reload_r[woff[3:1]][7:0] <= acc_r.data;
        end
      end
      if (acc_r.addr == hpp_pkg::ADDR_TIMER_EN) begin
        timer_en_r <= acc_r.data;
      end
      if (acc_r.addr == hpp_pkg::ADDR_EVT_MASK) begin
        evt_mask_r <= acc_r.data;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ind_sel_r  <= '0;
      ind_data_r <= '0;
    end else if (wr_pulse_r) begin
      if (acc_r.addr == hpp_pkg::ADDR_IND_SEL) begin
        ind_sel_r  <= acc_r.data[hpp_pkg::IND_AW-1:0];
        ind_data_r <= ind_mem[acc_r.data[hpp_pkg::IND_AW-1:0]];
      end else if (in_range(acc_r.addr, hpp_pkg::ADDR_IND_DATA, 4)) begin
        ind_data_r[2'(acc_r.addr - hpp_pkg::ADDR_IND_DATA)] <= acc_r.data;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_pulse_r && (acc_r.addr == hpp_pkg::ADDR_IND_DATA + 8'(hpp_pkg::IND_LAST_BYTE))) begin
      ind_mem[ind_sel_r] <= {acc_r.data, ind_data_r[2], ind_data_r[1], ind_data_r[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == 32'(TICK_CYC - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC - 1)) ? '0 : tick_cnt_r + 32'h00000001;
    end
  end

  generate
    for (genvar g = 0; g < hpp_pkg::NUM_TIMERS; g++) begin : g_tmr
      assign expire[g] = tick_r && timer_en_r[g] && (timer_cnt_r[g] == hpp_pkg::RST_WORD);
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          timer_cnt_r[g] <= hpp_pkg::RST_WORD;
        end else if (!timer_en_r[g]) begin
          timer_cnt_r[g] <= timer_reload_r[g];
        end else if (tick_r) begin
          timer_cnt_r[g] <= expire[g] ? timer_reload_r[g] : timer_cnt_r[g] - 16'h0001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt
  // sticky status, set wins
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_stat_r      <= hpp_pkg::RST_BYTE;
      irq_oe_o        <= 1'b0;
      timer_expired_o <= hpp_pkg::RST_BYTE;
    end else begin
      if (wr_pulse_r && acc_r.addr == hpp_pkg::ADDR_EVT_STAT) begin
        evt_stat_r <= (evt_stat_r & ~acc_r.data) | expire;
      end else begin
        evt_stat_r <= evt_stat_r | expire;
      end
      irq_oe_o        <= |(evt_stat_r & evt_mask_r);
      timer_expired_o <= expire;
    end
  end

endmodule

// [tb/hpp_host_model.sv]
// Host bus model driving strobes, address and data of the port
`timescale 1ns/100ps
module hpp_host_model (
  input  wire logic       clk_i,     // Bus clock
  input  wire logic       style_i,   // Strobe convention
  input  wire logic       mux_i,     // Shared address/data
  input  wire logic       ready_n_i, // Ready line, low = wait
  input  wire logic [7:0] bus_i,     // Resolved data lines
  output logic            cs_n_o,    // Chip select
  output logic            rd_ds_n_o, // Read or data strobe
  output logic            wr_rw_o,   // Write strobe or direction
  output logic            ale_o,     // Address latch
  output logic [7:0]      addr_o,    // Split address
  output logic [7:0]      ad_o       // Host data lines
);
  initial begin
    cs_n_o = 1'b1;
    rd_ds_n_o = 1'b1;
    wr_rw_o = 1'b1;
    ale_o = 1'b0;
    addr_o = 8'h00;
    ad_o = 8'h5A;
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic done);
    logic seen;
    seen = 1'b0;
    done = 1'b0;
    @(posedge clk_i);
    #1;
    if (mux_i) begin
      ad_o = a;
      ale_o = 1'b1;
      @(posedge clk_i);
      #1;
      ale_o = 1'b0;
    end
    addr_o = mux_i ? ~a : a;
    ad_o = wr ? d : ~ad_o;
    cs_n_o = 1'b0;
    rd_ds_n_o = style_i ? 1'b0 : wr;
    wr_rw_o = !wr;
    repeat (40) begin
      @(posedge clk_i);
      if (!ready_n_i) begin
        seen = 1'b1;
      end else if (seen) begin
        done = 1'b1;
        break;
      end
    end
    q = bus_i;
    #1;
    cs_n_o = 1'b1;
    rd_ds_n_o = 1'b1;
    wr_rw_o = 1'b1;
    ad_o = ~ad_o;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// [tb/hpp_checker_assertions.sv]
// Checker for the host processor port
`timescale 1ns/100ps
module hpp_checker #(
  parameter int WAIT_CYC = 4,
  parameter int TICK_CYC = 4
) (
  input wire logic       mclk_i,             // Clock
  input wire logic       rstn_i,             // Reset
  input wire logic       bus_style_select_i, // Convention
  input wire logic       cs_n_i,             // Select
  input wire logic       rd_ds_n_i,          // Strobe
  input wire logic       wr_rw_i,            // Strobe or direction
  input wire logic [7:0] ad_o,               // Read data
  input wire logic       ad_oe_o,            // Data drive
  input wire logic       ready_oe_o,         // Wait
  input wire logic       irq_oe_o,           // Interrupt
  input wire logic [7:0] timer_expired_o     // Timer pulses
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic       act;
  logic       is_rd;
  logic [7:0] wcnt_r;
  assign act = !cs_n_i && (!rd_ds_n_i || (!bus_style_select_i && !wr_rw_i));
  assign is_rd = bus_style_select_i ? wr_rw_i : !rd_ds_n_i;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) wcnt_r <= 8'h00;
    else wcnt_r <= ready_oe_o ? wcnt_r + 8'h01 : 8'h00;
  end
  a_wait_len: assert property ($fell(ready_oe_o) |-> wcnt_r == 8'(WAIT_CYC))
    else $error("wait length wrong");
  a_ready_start: assert property ($rose(act) |=> ready_oe_o)
    else $error("no wait after strobe");
  a_ready_cause: assert property ($rose(ready_oe_o) |-> $past(act))
    else $error("wait without strobe");
  a_rd_valid: assert property ($fell(ready_oe_o) && act && is_rd |-> ad_oe_o)
    else $error("read data not driven");
  a_oe_hold: assert property (ad_oe_o && act |=> ad_oe_o && $stable(ad_o))
    else $error("read data not held");
  a_oe_release: assert property (ad_oe_o && !act |=> !ad_oe_o)
    else $error("data lines not released");
  a_no_drv_wr: assert property (act && !is_rd |-> !ad_oe_o)
    else $error("drive during write");
  a_pulse_one: assert property (timer_expired_o != 8'h00 |=>
    (timer_expired_o & $past(timer_expired_o)) == 8'h00)
    else $error("timer pulse too long");
  c_read: cover property ($fell(ready_oe_o) && act && is_rd);
  c_write: cover property ($fell(ready_oe_o) && act && !is_rd);
  c_irq: cover property ($rose(irq_oe_o));
endmodule
bind hpp_host_processor_port hpp_checker #(.WAIT_CYC(WAIT_CYC), .TICK_CYC(TICK_CYC)) u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .bus_style_select_i(bus_style_select_i),
  .cs_n_i(cs_n_i), .rd_ds_n_i(rd_ds_n_i), .wr_rw_i(wr_rw_i), .ad_o(ad_o),
  .ad_oe_o(ad_oe_o), .ready_oe_o(ready_oe_o), .irq_oe_o(irq_oe_o),
  .timer_expired_o(timer_expired_o));

// [tb/tb_top.sv]
// Testbench for the host processor port
`timescale 1ns/100ps
module tb_top;
  logic             mclk, rstn, style, mux, cs_n, rd_ds_n, wr_rw, ale;
  logic             ad_oe, ready_oe, irq_oe;
  logic [9:0][15:0] meter;
  logic [7:0]       addr, host_ad, dut_ad, bus, texp;
  int               errors, num_checks, cyc;
  assign bus = ad_oe ? dut_ad : host_ad;
  always #2.5 mclk = ~mclk;
  hpp_host_processor_port #(.WAIT_CYC(4), .TICK_CYC(4)) DUT (
    .mclk_i(mclk), .rstn_i(rstn), .bus_style_select_i(style),
    .addr_data_mux_select_i(mux), .cs_n_i(cs_n), .rd_ds_n_i(rd_ds_n), .wr_rw_i(wr_rw),
    .ale_i(ale), .addr_i(addr), .ad_i(bus), .ad_o(dut_ad), .ad_oe_o(ad_oe),
    .ready_oe_o(ready_oe), .irq_oe_o(irq_oe), .meter_i(meter), .timer_expired_o(texp));
  hpp_host_model u_host (
    .clk_i(mclk), .style_i(style), .mux_i(mux), .ready_n_i(!ready_oe), .bus_i(bus),
    .cs_n_o(cs_n), .rd_ds_n_o(rd_ds_n), .wr_rw_o(wr_rw), .ale_o(ale), .addr_o(addr),
    .ad_o(host_ad));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] nq;
    logic       done;
    u_host.acc(1'b1, a, d, nq, done);
    chk({7'h00, done}, 8'h01);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       done;
    u_host.acc(1'b0, a, 8'h00, q, done);
    chk({7'h00, done}, 8'h01);
    chk(q, exp);
  endtask
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Timer reload round trip under every strap setting
  task automatic t_straps();
    logic [7:0] a;
    for (int m = 0; m < 4; m++) begin
      style = m[0];
      mux = m[1];
      a = 8'(2 * m);
      wr(a, {4'h3, 4'(m)});
      wr(a + 8'h01, {4'hC, 4'(m)});
      rd_chk(a, {4'h3, 4'(m)});
      rd_chk(a + 8'h01, {4'hC, 4'(m)});
    end
  endtask
  task automatic t_meter();
    rd_chk(8'h22, 8'hEF);
    rd_chk(8'h23, 8'hBE);
    wr(8'h12, 8'h99);
    rd_chk(8'h12, 8'h68);
    rd_chk(8'hFF, hpp_pkg::UNMAPPED_DATA);
  endtask
  task automatic t_indirect();
    wr(hpp_pkg::ADDR_IND_SEL, 8'h05);
    for (int i = 0; i < 4; i++) wr(8'h2C + 8'(i), 8'(8'h11 * (i + 1)));
    wr(8'h2C, 8'h00);
    wr(hpp_pkg::ADDR_IND_SEL, 8'h05);
    for (int i = 0; i < 4; i++) rd_chk(8'h2C + 8'(i), 8'(8'h11 * (i + 1)));
  endtask
  task automatic t_irq();
    int n;
    wr(8'h02, 8'h02);
    wr(8'h03, 8'h00);
    wr(hpp_pkg::ADDR_EVT_MASK, 8'h02);
    wr(hpp_pkg::ADDR_TIMER_EN, 8'h02);
    n = 0;
    while (texp[1] !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({7'h00, texp[1]}, 8'h01);
    repeat (3) @(posedge mclk);
    #1;
    chk({7'h00, irq_oe}, 8'h01);
    rd_chk(hpp_pkg::ADDR_EVT_STAT, 8'h02);
    wr(hpp_pkg::ADDR_TIMER_EN, 8'h00);
    wr(hpp_pkg::ADDR_EVT_STAT, 8'h02);
    repeat (3) @(posedge mclk);
    #1;
    chk({7'h00, irq_oe}, 8'h00);
  endtask
  // Mid-run reset clears outputs and registers
  task automatic t_reset();
    wr(hpp_pkg::ADDR_TIMER_EN, 8'h01);
    rstn = 1'b0;
    #1;
    chk(texp, hpp_pkg::RST_BYTE);
    chk({5'h00, ad_oe, ready_oe, irq_oe}, hpp_pkg::RST_BYTE);
    repeat (3) @(posedge mclk);
    #1;
    rstn = 1'b1;
    rd_chk(hpp_pkg::ADDR_TIMER_EN, hpp_pkg::RST_BYTE);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    style = 1'b0;
    mux = 1'b0;
    meter = '0;
    meter[1] = 16'h2468;
    meter[9] = 16'hBEEF;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    #1;
    rstn = 1'b1;
    t_straps();
    t_meter();
    t_indirect();
    t_irq();
    t_reset();
    end_of_test();
  end
endmodule
